// ==== rtl/asuc_core.sv ====
// asynchronous serial unit with axi4-lite register access
//
// Overview of operation
// - pins used only with power and enable
// - start, 7/8 lsb-first bits, parity, stops
// - even parity: even ones, odd is error
// - odd parity: odd ones, even is error
// - zero parity: send zero, never check
// - no parity: no parity bit at all
// - data write starts frame, bits auto-appended
// - done pulse right after last stop bit
// - transmitter idles until next data write
// - falling edge, wait divisor, confirm low
// - shift in, buffer on stop unless overrun
// - parity error does not abort frame
// - one receive pulse for data and errors
// - receiver checks only one stop bit
// - status read returns flags, clears them
// - parity, framing and overrun flag causes
// - input filtered by two agreeing samples
// - separate divider counters for tx, rx
// - power off clears status, data, buffer
// - enable off resets its own circuit
// - bit period is two divider periods
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "asuc_cfg.svh"
module asuc_core #(
   parameter int ADDR_W = 8,
   parameter int DIV_W = 5
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic serial_out_pin,
   output logic serial_out_oe,
   input wire logic serial_in_pin,
   output logic tx_done_irq,
   output logic rx_done_irq
);
   if (ADDR_W < 5 || DIV_W < 4) begin : g_chk
      $error("address or divisor width too small");
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers and bus slave

   logic [7:0] serial_mode_reg;
   logic [2:0] rx_error_status_reg;
   logic [DIV_W-1:0] baud_gen_ctrl_reg;
   logic [7:0] tx_shift_reg;
   logic [7:0] rx_shift_reg;
   logic [7:0] rx_buffer_reg;
   logic rx_full;

   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_go;
   logic wr_hit;
   logic rd_go;
   logic rd_hit;
   logic [31:0] rd_mux;

   logic unit_power_bit;
   logic tx_enable_bit;
   logic rx_enable_bit;
   logic char_length_sel;
   logic stop_length_sel;
   asuc_pkg::asuc_par_t par_mode;
   logic [DIV_W-1:0] div_eff;

   asuc_pkg::asuc_tx_state_t tx_state;
   asuc_pkg::asuc_rx_state_t rx_state;

   assign unit_power_bit = serial_mode_reg[`ASUC_MODE_POWER];
   assign tx_enable_bit = serial_mode_reg[`ASUC_MODE_TXE];
   assign rx_enable_bit = serial_mode_reg[`ASUC_MODE_RXE];
   assign char_length_sel = serial_mode_reg[`ASUC_MODE_CL];
   assign stop_length_sel = serial_mode_reg[`ASUC_MODE_SL];
   assign par_mode = asuc_pkg::asuc_par_t'(serial_mode_reg[`ASUC_MODE_PAR_HI:`ASUC_MODE_PAR_LO]);
   // prohibited small divisors run as the least legal one
   assign div_eff = (baud_gen_ctrl_reg < DIV_W'(`ASUC_DIV_MIN)) ? DIV_W'(`ASUC_DIV_MIN) : baud_gen_ctrl_reg;

   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_go = aw_held && w_held && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;

   always_comb begin
      wr_hit = (aw_addr == ADDR_W'(`ASUC_OFS_MODE)) || (aw_addr == ADDR_W'(`ASUC_OFS_ERR))
         || (aw_addr == ADDR_W'(`ASUC_OFS_BAUD)) || (aw_addr == ADDR_W'(`ASUC_OFS_TXD))
         || (aw_addr == ADDR_W'(`ASUC_OFS_RXB)) || (aw_addr == ADDR_W'(`ASUC_OFS_STAT));
   end

   logic mode_wr;
   logic baud_wr;
   logic tx_wr;
   logic err_rd;
   logic buf_rd;
   assign mode_wr = wr_go && w_strb[0] && (aw_addr == ADDR_W'(`ASUC_OFS_MODE));
   assign baud_wr = wr_go && w_strb[0] && (aw_addr == ADDR_W'(`ASUC_OFS_BAUD));
   // writes while busy or disabled are dropped
   assign tx_wr = wr_go && w_strb[0] && (aw_addr == ADDR_W'(`ASUC_OFS_TXD))
      && unit_power_bit && tx_enable_bit && (tx_state == asuc_pkg::tx_idle);
   assign err_rd = rd_go && (s_axi_araddr == ADDR_W'(`ASUC_OFS_ERR));
   assign buf_rd = rd_go && (s_axi_araddr == ADDR_W'(`ASUC_OFS_RXB));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ASUC_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? `ASUC_RESP_OKAY : `ASUC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         ADDR_W'(`ASUC_OFS_MODE): rd_mux[7:0] = {serial_mode_reg[7:1], 1'b1};
         ADDR_W'(`ASUC_OFS_ERR): rd_mux[2:0] = rx_error_status_reg;
         ADDR_W'(`ASUC_OFS_BAUD): rd_mux[DIV_W-1:0] = baud_gen_ctrl_reg;
         ADDR_W'(`ASUC_OFS_TXD): rd_mux[7:0] = tx_shift_reg;
         ADDR_W'(`ASUC_OFS_RXB): rd_mux[7:0] = rx_buffer_reg;
         ADDR_W'(`ASUC_OFS_STAT): begin
            rd_mux[`ASUC_STAT_TXBUSY] = (tx_state != asuc_pkg::tx_idle);
            rd_mux[`ASUC_STAT_RXFULL] = rx_full;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `ASUC_RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_hit ? `ASUC_RESP_OKAY : `ASUC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_mode_reg <= `ASUC_MODE_RST;
         baud_gen_ctrl_reg <= DIV_W'(`ASUC_DIV_RST);
      end else begin
         if (mode_wr) begin
            serial_mode_reg <= {w_data[7:1], 1'b1};
         end
         if (baud_wr) begin
            baud_gen_ctrl_reg <= w_data[DIV_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmitter

   logic tx_tick;
   logic tx_half;
   logic [2:0] tx_idx;
   logic tx_line;
   logic tx_par_bit;
   logic [7:0] tx_char;
   logic [2:0] last_idx;

   assign last_idx = char_length_sel ? 3'd7 : 3'd6;
   assign tx_char = char_length_sel ? tx_shift_reg : {1'b0, tx_shift_reg[6:0]};

   always_comb begin
      unique case (par_mode)
         asuc_pkg::par_even: tx_par_bit = ^tx_char;
         asuc_pkg::par_odd: tx_par_bit = ~^tx_char;
         asuc_pkg::par_zero: tx_par_bit = 1'b0;
         asuc_pkg::par_none: tx_par_bit = 1'b0;
      endcase
   end

   // counter restarts on each accepted data write so the start bit is full length
   asuc_divider #(.W(DIV_W)) u_tx_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(unit_power_bit && tx_enable_bit),
      .clear(tx_wr),
      .divisor(div_eff),
      .tick(tx_tick)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn || !unit_power_bit) begin
         tx_shift_reg <= 8'h00;
      end else if (tx_wr) begin
         tx_shift_reg <= w_data[7:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !unit_power_bit || !tx_enable_bit) begin
         tx_state <= asuc_pkg::tx_idle;
         tx_line <= 1'b1;
         tx_half <= 1'b0;
         tx_idx <= 3'd0;
         tx_done_irq <= 1'b0;
      end else begin
         tx_done_irq <= 1'b0;
         if (tx_wr) begin
            tx_state <= asuc_pkg::tx_start;
            tx_line <= 1'b0;
            tx_half <= 1'b0;
            tx_idx <= 3'd0;
         end else if (tx_tick) begin
            tx_half <= !tx_half;
            if (tx_half) begin
               unique case (tx_state)
                  asuc_pkg::tx_start: begin
                     tx_line <= tx_char[0];
                     tx_state <= asuc_pkg::tx_data;
                  end
                  asuc_pkg::tx_data: begin
                     if (tx_idx == last_idx) begin
                        tx_idx <= 3'd0;
                        if (par_mode == asuc_pkg::par_none) begin
                           tx_line <= 1'b1;
                           tx_state <= asuc_pkg::tx_stop;
                        end else begin
                           tx_line <= tx_par_bit;
                           tx_state <= asuc_pkg::tx_parity;
                        end
                     end else begin
                        tx_idx <= tx_idx + 3'd1;
                        tx_line <= tx_char[tx_idx + 3'd1];
                     end
                  end
                  asuc_pkg::tx_parity: begin
                     tx_line <= 1'b1;
                     tx_state <= asuc_pkg::tx_stop;
                  end
                  asuc_pkg::tx_stop: begin
                     if (stop_length_sel && tx_idx == 3'd0) begin
                        tx_idx <= 3'd1;
                     end else begin
                        tx_state <= asuc_pkg::tx_idle;
                        tx_done_irq <= 1'b1;
                     end
                  end
                  asuc_pkg::tx_idle: tx_line <= 1'b1;
               endcase
            end
         end
      end
   end

   assign serial_out_pin = tx_line;
   assign serial_out_oe = unit_power_bit && tx_enable_bit;

   ////////////////////////////////////////////////////////////////////////////
   // receiver

   logic rx_filt;
   logic rx_prev;
   logic rx_tick;
   logic rx_half;
   logic [2:0] rx_idx;
   logic rx_par;
   logic rx_fall;
   logic frame_end;
   logic pe_now;
   logic [2:0] err_set;

   asuc_filter u_rx_filt (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(unit_power_bit && rx_enable_bit),
      .pin_in(serial_in_pin),
      .filt_out(rx_filt)
   );

   assign rx_fall = rx_prev && !rx_filt && (rx_state == asuc_pkg::rx_idle);

   asuc_divider #(.W(DIV_W)) u_rx_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(rx_state != asuc_pkg::rx_idle),
      .clear(rx_fall),
      .divisor(div_eff),
      .tick(rx_tick)
   );

   // one stop bit checked; a second one simply looks like idle line
   assign frame_end = (rx_state == asuc_pkg::rx_stop) && rx_tick && rx_half;
   assign pe_now = ((par_mode == asuc_pkg::par_even) && rx_par)
      || ((par_mode == asuc_pkg::par_odd) && !rx_par);

   always_comb begin
      err_set = 3'b000;
      if (frame_end) begin
         err_set[`ASUC_ERR_PE] = pe_now;
         err_set[`ASUC_ERR_FE] = !rx_filt;
         err_set[`ASUC_ERR_OVE] = rx_full;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !unit_power_bit || !rx_enable_bit) begin
         rx_state <= asuc_pkg::rx_idle;
         rx_prev <= 1'b1;
         rx_half <= 1'b0;
         rx_idx <= 3'd0;
         rx_par <= 1'b0;
         rx_shift_reg <= 8'h00;
         rx_done_irq <= 1'b0;
      end else begin
         rx_prev <= rx_filt;
         rx_done_irq <= frame_end;
         unique case (rx_state)
            asuc_pkg::rx_idle: begin
               if (rx_fall) begin
                  rx_state <= asuc_pkg::rx_start;
               end
            end
            asuc_pkg::rx_start: begin
               if (rx_tick) begin
                  rx_half <= 1'b0;
                  rx_idx <= 3'd0;
                  rx_par <= 1'b0;
                  rx_state <= rx_filt ? asuc_pkg::rx_idle : asuc_pkg::rx_data;
               end
            end
            asuc_pkg::rx_data: begin
               if (rx_tick) begin
                  rx_half <= !rx_half;
                  if (rx_half) begin
                     rx_shift_reg[rx_idx] <= rx_filt;
                     rx_par <= rx_par ^ rx_filt;
                     if (rx_idx == last_idx) begin
                        rx_state <= (par_mode == asuc_pkg::par_none) ? asuc_pkg::rx_stop : asuc_pkg::rx_parity;
                     end else begin
                        rx_idx <= rx_idx + 3'd1;
                     end
                  end
               end
            end
            asuc_pkg::rx_parity: begin
               if (rx_tick) begin
                  rx_half <= !rx_half;
                  if (rx_half) begin
                     rx_par <= rx_par ^ rx_filt;
                     rx_state <= asuc_pkg::rx_stop;
                  end
               end
            end
            asuc_pkg::rx_stop: begin
               if (rx_tick) begin
                  rx_half <= !rx_half;
                  if (rx_half) begin
                     rx_state <= asuc_pkg::rx_idle;
                  end
               end
            end
         endcase
      end
   end

   // buffer is kept on overrun so the unread character survives
   always_ff @(posedge aclk) begin
      if (!aresetn || !unit_power_bit) begin
         rx_buffer_reg <= 8'h00;
         rx_full <= 1'b0;
      end else begin
         if (frame_end && !rx_full) begin
            rx_buffer_reg <= char_length_sel ? rx_shift_reg : {1'b0, rx_shift_reg[6:0]};
         end
         rx_full <= (rx_full && !buf_rd) || frame_end;
      end
   end

   // a new error in the clearing read cycle wins over the clear
   always_ff @(posedge aclk) begin
      if (!aresetn || !unit_power_bit) begin
         rx_error_status_reg <= 3'b000;
      end else begin
         rx_error_status_reg <= (rx_error_status_reg & {3{!err_rd}}) | err_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_tx_load;
      tx_wr;
   endsequence
   sequence s_start_out;
      !serial_out_pin && tx_state == asuc_pkg::tx_start;
   endsequence

   a_tx_start_bit: assert property (s_tx_load |=> s_start_out)
      else $error("data write did not start a frame with a low start bit");
   // enable drops a cycle before the engine resets, so look one edge back
   a_tx_pin_gate: assert property (tx_state != asuc_pkg::tx_idle |-> $past(serial_out_oe))
      else $error("frame running while output pin not driven");
   a_tx_idle_high: assert property (tx_state == asuc_pkg::tx_idle |-> serial_out_pin)
      else $error("output not high while idle");
   a_tx_done_stop: assert property (tx_done_irq |-> $past(tx_state) == asuc_pkg::tx_stop
      && tx_state == asuc_pkg::tx_idle)
      else $error("transmit done not right after last stop bit");
   a_zero_parity: assert property ((tx_state == asuc_pkg::tx_parity && par_mode == asuc_pkg::par_zero)
      |-> !serial_out_pin)
      else $error("zero parity bit sent as one");
   a_rx_start_fail: assert property ((rx_state == asuc_pkg::rx_start && rx_tick && rx_filt)
      |=> rx_state == asuc_pkg::rx_idle)
      else $error("start bit accepted though line was high");
   a_err_irq: assert property ((rx_error_status_reg & ~$past(rx_error_status_reg)) != 3'b000
      |-> rx_done_irq)
      else $error("error flag set without receive pulse");
   a_err_read_clear: assert property ((err_rd && !frame_end && unit_power_bit)
      |=> rx_error_status_reg == 3'b000)
      else $error("status read did not clear flags");
   a_overrun_keep: assert property ((frame_end && rx_full && unit_power_bit)
      |=> rx_error_status_reg[`ASUC_ERR_OVE] && rx_buffer_reg == $past(rx_buffer_reg))
      else $error("overrun not flagged or buffer overwritten");
   a_power_off: assert property (!unit_power_bit |=> rx_error_status_reg == 3'b000
      && !rx_full && tx_shift_reg == 8'h00)
      else $error("power off did not clear unit state");
   a_rxe_reset: assert property (!rx_enable_bit |=> rx_state == asuc_pkg::rx_idle)
      else $error("receiver running while disabled");
endmodule

// ==== shared/asuc_cfg.svh ====
// register offsets, field positions, reset values and codes of the serial unit
`ifndef ASUC_CFG_SVH
`define ASUC_CFG_SVH

`define ASUC_OFS_MODE 8'h00
`define ASUC_OFS_ERR 8'h04
`define ASUC_OFS_BAUD 8'h08
`define ASUC_OFS_TXD 8'h0c
`define ASUC_OFS_RXB 8'h10
`define ASUC_OFS_STAT 8'h14

`define ASUC_MODE_POWER 7
`define ASUC_MODE_TXE 6
`define ASUC_MODE_RXE 5
`define ASUC_MODE_PAR_HI 4
`define ASUC_MODE_PAR_LO 3
`define ASUC_MODE_CL 2
`define ASUC_MODE_SL 1
`define ASUC_MODE_RST 8'h01

`define ASUC_ERR_PE 2
`define ASUC_ERR_FE 1
`define ASUC_ERR_OVE 0

`define ASUC_STAT_TXBUSY 0
`define ASUC_STAT_RXFULL 1

`define ASUC_DIV_RST 5'h1f
`define ASUC_DIV_MIN 5'h08

`define ASUC_PAR_NONE 2'h0
`define ASUC_PAR_ZERO 2'h1
`define ASUC_PAR_ODD 2'h2
`define ASUC_PAR_EVEN 2'h3

`define ASUC_RESP_OKAY 2'h0
`define ASUC_RESP_SLVERR 2'h2

`endif

// ==== shared/asuc_pkg.sv ====
// types shared by the serial unit
`include "asuc_cfg.svh"
package asuc_pkg;
   typedef enum logic [1:0] {
      par_none = `ASUC_PAR_NONE,
      par_zero = `ASUC_PAR_ZERO,
      par_odd = `ASUC_PAR_ODD,
      par_even = `ASUC_PAR_EVEN
   } asuc_par_t;
   typedef enum logic [2:0] {tx_idle, tx_start, tx_data, tx_parity, tx_stop} asuc_tx_state_t;
   typedef enum logic [2:0] {rx_idle, rx_start, rx_data, rx_parity, rx_stop} asuc_rx_state_t;
endpackage

// ==== rtl/asuc_divider.sv ====
// programmable divider counter giving one tick every divisor cycles
`timescale 1ns/1ps
module asuc_divider #(
   parameter int W = 5
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   input wire logic clear,
   input wire logic [W-1:0] divisor,
   output logic tick
);
   if (W < 4) begin : g_chk
      $error("divider width too small for the least divisor");
   end

   logic [W-1:0] count;

   assign tick = run && !clear && (count == (divisor - W'(1)));

   always_ff @(posedge aclk) begin
      if (!aresetn || !run || clear) begin
         count <= '0;
      end else if (tick) begin
         count <= '0;
      end else begin
         count <= count + W'(1);
      end
   end

   // divisor is never below 8, so ticks stand at least 8 cycles apart
   a_div_tick_gap: assert property (@(posedge aclk) disable iff (!aresetn)
      tick |=> (!tick)[*7])
      else $error("divider ticks closer than the least divisor");
endmodule

// ==== rtl/asuc_filter.sv ====
// synchroniser and two-sample match filter for the serial input
`timescale 1ns/1ps
module asuc_filter (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic enable,
   input wire logic pin_in,
   output logic filt_out
);
   logic sync_a;
   logic sync_b;
   logic samp;

   // disabled input reads as idle high
   always_ff @(posedge aclk) begin
      if (!aresetn || !enable) begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
         samp <= 1'b1;
         filt_out <= 1'b1;
      end else begin
         sync_a <= pin_in;
         sync_b <= sync_a;
         samp <= sync_b;
         if (samp == sync_b) begin
            filt_out <= sync_b;
         end
      end
   end

   a_filt_agree: assert property (@(posedge aclk) disable iff (!aresetn)
      ($changed(filt_out) && $past(enable) && $past(enable, 2))
      |-> ($past(sync_b) == filt_out && $past(sync_b, 2) == filt_out))
      else $error("filter output changed without two agreeing samples");
endmodule

// ==== verification/asuc_node.sv ====
// remote serial node model for the bench
`timescale 1ns/1ps
module asuc_node (
   input wire logic aclk,
   input wire logic line_in,
   output logic line_out
);
   initial line_out = 1'b1;
   //////////////////////////////////////////
   // low start, then bits lsb first
   task automatic send(input logic [11:0] v, input int n, input int k);
      line_out <= 1'b0;
      repeat (2 * k) @(posedge aclk);
      for (int i = 0; i < n; i++) begin
         line_out <= v[i];
         repeat (2 * k) @(posedge aclk);
      end
      line_out <= 1'b1;
   endtask
   // far edge sampling, avoids racing the pin flop
   task automatic get(output logic [11:0] v, input int n, input int k);
      v = 12'h000;
      @(negedge line_in);
      repeat (k) @(negedge aclk);
      for (int i = 0; i < n; i++) begin
         repeat (2 * k) @(negedge aclk);
         v[i] = line_in;
      end
   endtask
endmodule

// ==== verification/async_serial_uart_core_tb.sv ====
// self-checking bench for the serial unit
`timescale 1ns/1ps
`include "asuc_cfg.svh"
module async_serial_uart_core_tb;
   localparam int K = 8;
   logic aclk = 0;
   logic aresetn = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, d;
   logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_in_pin;
   logic serial_out_pin, serial_out_oe, tx_done_irq, rx_done_irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [11:0] e, got;
   int n_fail = 0, compares = 0, n_tx = 0, n_rx = 0, pos;
   asuc_core i_dut (.*);
   asuc_node i_node (.aclk(aclk), .line_in(serial_out_pin), .line_out(serial_in_pin));
   always #25 aclk = ~aclk;
   // one-cycle pulses, so one far-edge look each
   always @(negedge aclk) begin
      if (tx_done_irq === 1'b1) n_tx++;
      if (rx_done_irq === 1'b1) n_rx++;
   end
   //////////////////////////////////////////
   task automatic chk(input string n, input logic [11:0] x, input logic [11:0] g);
      compares++;
      if (g !== x) begin
         $display("[ERR] %s exp %h got %h", n, x, g);
         n_fail++;
      end
   endtask
   // ready looked at on the far edge: the value the next rising edge takes
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      logic ah, wh, bh;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         ah = s_axi_awvalid & s_axi_awready;
         wh = s_axi_wvalid & s_axi_wready;
         bh = s_axi_bvalid;
         rr = s_axi_bresp;
         @(posedge aclk);
         if (ah) s_axi_awvalid <= 1'b0;
         if (wh) s_axi_wvalid <= 1'b0;
      end while (!bh);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [11:0] x, input string n);
      logic hs, v;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         hs = s_axi_arready;
         v = s_axi_rvalid;
         rd = s_axi_rdata;
         rr = s_axi_rresp;
         @(posedge aclk);
         if (hs) s_axi_arvalid <= 1'b0;
      end while (!v);
      s_axi_rready <= 1'b0;
      chk(n, x, rd[11:0]);
   endtask
   function automatic logic [7:0] md(input int p, input logic cl, input logic sl, input logic en);
      return {1'b1, en, en, 2'(p), cl, sl, 1'b1};
   endfunction
   task automatic give_verdict;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #1_000_000;
      n_fail++;
      give_verdict();
   end
   //////////////////////////////////////////
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rc(`ASUC_OFS_MODE, 12'h001, "mode");
      rc(`ASUC_OFS_BAUD, 12'h01f, "baud");
      rc(8'h18, 12'h000, "unmapped");
      chk("resp", 12'h002, {10'h000, rr});
      wr(8'h18, 8'h00);
      chk("wresp", 12'h002, {10'h000, rr});
      chk("oe", 12'h000, {11'h000, serial_out_oe});
      $display("test reset done");
      wr(`ASUC_OFS_BAUD, 8'h08);
      chk("wresp ok", 12'h000, {10'h000, rr});
      for (int m = 0; m < 4; m++) begin
         wr(`ASUC_OFS_MODE, md(m, m[0], m[1], 0));
         wr(`ASUC_OFS_MODE, md(m, m[0], m[1], 1));
         chk("oe", 12'h001, {11'h000, serial_out_oe});
         d = m[0] ? 8'hb5 : 8'h35;
         e = {4'h0, d};
         pos = m[0] ? 8 : 7;
         if (m != 0) begin
            e[pos] = (m == 3) ? ^d : (m == 2) ? ~^d : 1'b0;
            pos++;
         end
         e[pos] = 1'b1;
         e[pos+1] = m[1];
         fork
            i_node.get(got, pos + 1 + m[1], K);
            wr(`ASUC_OFS_TXD, d);
         join
         chk("tx frame", e, got);
         repeat (2 * K) @(posedge aclk);
         chk("tx irq", 12'(m + 1), 12'(n_tx));
         chk("tx idle", 12'h001, {11'h000, serial_out_pin});
      end
      $display("test transmit done");
      for (int m = 0; m < 4; m++) begin
         wr(`ASUC_OFS_MODE, md(m, 1, 0, 0));
         wr(`ASUC_OFS_MODE, md(m, 1, 0, 1));
         // parity deliberately wrong where it is checked
         e = (m == 0) ? 12'h10b : {2'h0, 1'b1, m != 3, 8'h0b};
         i_node.send(e, (m == 0) ? 9 : 10, K);
         repeat (8) @(posedge aclk);
         chk("rx irq", 12'(m + 1), 12'(n_rx));
         rc(`ASUC_OFS_ERR, (m > 1) ? 12'h004 : 12'h000, "parity");
         rc(`ASUC_OFS_ERR, 12'h000, "err clear");
         rc(`ASUC_OFS_RXB, 12'h00b, "rx data");
      end
      i_node.send(12'h10b, 10, K);
      repeat (8) @(posedge aclk);
      rc(`ASUC_OFS_ERR, 12'h002, "framing");
      rc(`ASUC_OFS_RXB, 12'h00b, "fe data");
      // low pulse shorter than the divisor: start must be refused
      i_node.send(12'h000, 0, 2);
      repeat (4 * K) @(posedge aclk);
      chk("glitch", 12'h005, 12'(n_rx));
      wr(`ASUC_OFS_MODE, md(0, 1, 1, 0));
      wr(`ASUC_OFS_MODE, md(0, 1, 1, 1));
      i_node.send(12'h15a, 9, K);
      @(posedge aclk);
      i_node.send(12'h1a5, 9, K);
      repeat (8) @(posedge aclk);
      chk("rx irq", 12'h007, 12'(n_rx));
      rc(`ASUC_OFS_ERR, 12'h001, "overrun");
      rc(`ASUC_OFS_STAT, 12'h002, "stat full");
      rc(`ASUC_OFS_RXB, 12'h05a, "kept");
      $display("test receive done");
      wr(`ASUC_OFS_MODE, 8'h01);
      rc(`ASUC_OFS_RXB, 12'h000, "rxb off");
      chk("oe", 12'h000, {11'h000, serial_out_oe});
      $display("test power done");
      give_verdict();
   end
endmodule
